//--- design/amts_beat_cnt.sv
// remaining beat counter of a write burst
module amts_beat_cnt (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [7:0] load_len,
    input wire logic step,
    output logic last
);
    logic [7:0] left_r;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            left_r <= 8'h00;
        else if (load)
            left_r <= load_len;
        else if (step && left_r != 8'h00)
            left_r <= left_r - 8'h01;
    end

    assign last = (left_r == 8'h00);
endmodule : amts_beat_cnt

//--- design/amts_byte_store_gen.sv
// byte lane strobes for one write beat
module amts_byte_store_gen (
    input wire logic [2:0] lane_addr,
    input wire logic [2:0] beat_size,
    output logic [7:0] byte_store
);
    logic [7:0] mask;

    always_comb
    begin
        case (beat_size)
            amts_pkg::AMTS_SIZE_8: mask = 8'h01;
            amts_pkg::AMTS_SIZE_16: mask = 8'h03;
            amts_pkg::AMTS_SIZE_32: mask = 8'h0F;
            default: mask = 8'hFF;
        endcase
        byte_store = 8'(mask << lane_addr);
    end
endmodule : amts_byte_store_gen

//--- design/amts_top.sv
// processor request to axi master transaction shaper
// Notes on behaviour
// - no burst carries more than 32 bytes of data
// - burst length never exceeds 8 transfers
// - no transaction crosses a 32-byte boundary; longer ones split
// - write channel only incr; fixed never issued anywhere
// - wrap reads only for cacheable non-shared linefills, 64-bit, 4 beats, aligned
// - 8-bit or 16-bit transfers always have one beat
// - transfer size never above 64 bits
// - instruction fetches flagged in prot bit 2, 64-bit, never locked or exclusive
// - unaligned device or strongly ordered access faults, no bus transfer
// - write data of different bursts never interleaved
// - write response and read data ready held high permanently
// - aligned strongly ordered and device accesses always reach the bus
// - non-cacheable normal accesses may be absorbed by the store buffer
// - device accesses keep instruction size; multiples and doublewords use 32-bit
// - device byte load: exact address, incr, 8-bit, one beat
// - device halfword load: 16-bit incr single; odd address faults
// - device word load: 32-bit incr single; unaligned faults
// - device multi load: incr 32-bit bursts totalling register count, split at 32-byte boundaries
// - device byte store: 8-bit single, one strobe from address bits 2:0
// - device halfword store: 16-bit single, strobe pair; odd address faults
// - only wb or wt non-shared normal memory cached; device never
module amts_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire amts_pkg::amts_op_type req_op,
    input wire amts_pkg::amts_mem_type req_mem,
    input wire logic req_shared,
    input wire logic req_instr,
    input wire logic req_excl,
    input wire logic req_lock,
    input wire logic req_sb_hit,
    input wire logic [31:0] req_addr,
    input wire logic [4:0] req_nwords,
    input wire logic st_valid,
    output logic st_ready,
    input wire logic [63:0] st_data,
    output logic align_fault,
    output logic sb_absorbed,
    output logic [63:0] ld_data,
    output logic ld_valid,
    output logic ld_last,
    output logic [1:0] ld_resp,
    output logic st_done,
    output logic [1:0] st_resp,
    output logic [31:0] araddr,
    output logic [1:0] arburst,
    output logic [2:0] arsize,
    output logic [7:0] arlen,
    output logic [1:0] arlock,
    output logic [2:0] arprot,
    output logic arvalid,
    input wire logic arready,
    output logic [31:0] awaddr,
    output logic [1:0] awburst,
    output logic [2:0] awsize,
    output logic [7:0] awlen,
    output logic [1:0] awlock,
    output logic [2:0] awprot,
    output logic awvalid,
    input wire logic awready,
    output logic [63:0] wdata,
    output logic [7:0] wstrb,
    output logic wlast,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    input wire logic [63:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rlast,
    input wire logic rvalid,
    output logic rready
);
    amts_pkg::amts_state_type state_r;
    amts_pkg::amts_state_type state_nxt;
    amts_pkg::amts_op_type job_op_r;
    amts_pkg::amts_mem_type job_mem_r;
    logic job_write_r;
    logic job_instr_r;
    logic job_fill_ok_r;
    logic [1:0] job_lock_r;
    logic [31:0] job_addr_r;
    logic [4:0] job_rem_r;
    logic dev_mem;
    logic misalign;
    logic absorb;
    logic take_req;
    logic [3:0] room;
    logic [3:0] take_w;
    logic [31:0] sh_addr;
    logic [1:0] sh_burst;
    logic [2:0] sh_size;
    logic [7:0] sh_len;
    logic multi_op;
    logic ar_hs;
    logic aw_hs;
    logic w_hs;
    logic st_take;
    logic wvalid_nxt;
    logic beat_last;
    logic w_all_r;
    logic [2:0] w_lane_r;
    logic [2:0] w_size_r;
    logic [7:0] beat_byte_store;

    assign dev_mem = (req_mem == amts_pkg::AMTS_MEM_SO) || (req_mem == amts_pkg::AMTS_MEM_DEV);
    assign take_req = req_valid && req_ready;
    assign ar_hs = arvalid && arready;
    assign aw_hs = awvalid && awready;
    assign w_hs = wvalid && wready;
    assign st_take = st_valid && st_ready;
    assign multi_op = (job_op_r == amts_pkg::AMTS_OP_MULTI) || (job_op_r == amts_pkg::AMTS_OP_DWORD);

    always_comb
    begin
        misalign = 1'b0;
        if (dev_mem || req_excl || req_lock)
        begin
            case (req_op)
                amts_pkg::AMTS_OP_HALF: misalign = req_addr[0];
                amts_pkg::AMTS_OP_WORD,
                amts_pkg::AMTS_OP_MULTI,
                amts_pkg::AMTS_OP_DWORD: misalign = (req_addr[1:0] != 2'h0);
                default: misalign = 1'b0;
            endcase
        end
    end

    // store buffer may serve normal nc
    assign absorb = !misalign && req_sb_hit && (req_mem == amts_pkg::AMTS_MEM_NC)
        && (req_op <= amts_pkg::AMTS_OP_DWORD);

    assign room = amts_pkg::AMTS_WORDS_PER_REGION - {1'b0, job_addr_r[4:2]};
    assign take_w = ({1'b0, room} > job_rem_r) ? job_rem_r[3:0] : room;

    always_comb
    begin
        sh_addr = job_addr_r;
        sh_burst = amts_pkg::AMTS_BURST_INCR;
        sh_size = amts_pkg::AMTS_SIZE_32;
        sh_len = amts_pkg::AMTS_LEN_1;
        case (job_op_r)
            amts_pkg::AMTS_OP_BYTE: sh_size = amts_pkg::AMTS_SIZE_8;
            amts_pkg::AMTS_OP_HALF: sh_size = amts_pkg::AMTS_SIZE_16;
            amts_pkg::AMTS_OP_WORD: sh_size = amts_pkg::AMTS_SIZE_32;
            amts_pkg::AMTS_OP_MULTI,
            amts_pkg::AMTS_OP_DWORD: sh_len = {4'h0, take_w - 4'h1};
            amts_pkg::AMTS_OP_FETCH:
            begin
                sh_size = amts_pkg::AMTS_SIZE_64;
                sh_addr = {job_addr_r[31:3], 3'h0};
            end
            amts_pkg::AMTS_OP_LINEFILL:
            begin
                sh_size = amts_pkg::AMTS_SIZE_64;
                sh_addr = {job_addr_r[31:3], 3'h0};
                if (job_fill_ok_r)
                begin
                    sh_burst = amts_pkg::AMTS_BURST_WRAP;
                    sh_len = amts_pkg::AMTS_LEN_4;
                end
            end
            amts_pkg::AMTS_OP_EVICT:
            begin
                sh_size = amts_pkg::AMTS_SIZE_64;
                sh_len = amts_pkg::AMTS_LEN_4;
                sh_addr = {job_addr_r[31:5], 5'h00};
            end
            default: sh_size = amts_pkg::AMTS_SIZE_32;
        endcase
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            amts_pkg::AMTS_ST_IDLE:
                if (take_req && !misalign && !absorb)
                    state_nxt = amts_pkg::AMTS_ST_ISSUE;
            amts_pkg::AMTS_ST_ISSUE: state_nxt = amts_pkg::AMTS_ST_ADDR;
            amts_pkg::AMTS_ST_ADDR:
                if (aw_hs)
                    state_nxt = amts_pkg::AMTS_ST_DATA;
                else if (ar_hs)
                    state_nxt = (job_rem_r != 5'h00) ? amts_pkg::AMTS_ST_ISSUE
                        : amts_pkg::AMTS_ST_IDLE;
            // next burst waits for last beat
            amts_pkg::AMTS_ST_DATA:
                if (w_hs && wlast)
                    state_nxt = (job_rem_r != 5'h00) ? amts_pkg::AMTS_ST_ISSUE
                        : amts_pkg::AMTS_ST_IDLE;
            default: state_nxt = amts_pkg::AMTS_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            state_r <= amts_pkg::AMTS_ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            req_ready <= 1'b0;
        else
            req_ready <= (state_nxt == amts_pkg::AMTS_ST_IDLE) && !take_req;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            align_fault <= 1'b0;
            sb_absorbed <= 1'b0;
        end
        else
        begin
            align_fault <= take_req && misalign;
            sb_absorbed <= take_req && absorb;
        end
    end

    // job capture and split advance
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            job_op_r <= amts_pkg::AMTS_OP_BYTE;
            job_mem_r <= amts_pkg::AMTS_MEM_SO;
            job_write_r <= 1'b0;
            job_instr_r <= 1'b0;
            job_fill_ok_r <= 1'b0;
            job_lock_r <= amts_pkg::AMTS_LOCK_NORMAL;
            job_addr_r <= amts_pkg::AMTS_ADDR_RST;
            job_rem_r <= 5'h00;
        end
        else if (take_req && !misalign && !absorb)
        begin
            job_op_r <= req_op;
            job_mem_r <= req_mem;
            job_write_r <= req_write || (req_op == amts_pkg::AMTS_OP_EVICT);
            job_instr_r <= req_instr || (req_op == amts_pkg::AMTS_OP_FETCH);
            // only wb or wt non-shared fill
            job_fill_ok_r <= !req_shared && ((req_mem == amts_pkg::AMTS_MEM_WB)
                || (req_mem == amts_pkg::AMTS_MEM_WT));
            if (req_instr || req_op == amts_pkg::AMTS_OP_FETCH)
                job_lock_r <= amts_pkg::AMTS_LOCK_NORMAL;
            else if (req_lock)
                job_lock_r <= amts_pkg::AMTS_LOCK_LOCKED;
            else if (req_excl)
                job_lock_r <= amts_pkg::AMTS_LOCK_EXCL;
            else
                job_lock_r <= amts_pkg::AMTS_LOCK_NORMAL;
            job_addr_r <= req_addr;
            if (req_op == amts_pkg::AMTS_OP_MULTI)
                job_rem_r <= req_nwords;
            else if (req_op == amts_pkg::AMTS_OP_DWORD)
                job_rem_r <= amts_pkg::AMTS_DWORD_WORDS;
            else
                job_rem_r <= 5'h00;
        end
        else if (state_r == amts_pkg::AMTS_ST_ISSUE && multi_op)
        begin
            job_addr_r <= job_addr_r + {26'h0, take_w, 2'b00};
            job_rem_r <= job_rem_r - {1'b0, take_w};
        end
    end

    // read address channel
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            arvalid <= 1'b0;
            araddr <= amts_pkg::AMTS_ADDR_RST;
            arburst <= amts_pkg::AMTS_BURST_INCR;
            arsize <= amts_pkg::AMTS_SIZE_8;
            arlen <= amts_pkg::AMTS_LEN_1;
            arlock <= amts_pkg::AMTS_LOCK_NORMAL;
            arprot <= amts_pkg::AMTS_PROT_DATA;
        end
        else if (state_r == amts_pkg::AMTS_ST_ISSUE && !job_write_r)
        begin
            arvalid <= 1'b1;
            araddr <= sh_addr;
            arburst <= sh_burst;
            arsize <= sh_size;
            arlen <= sh_len;
            arlock <= job_lock_r;
            arprot <= job_instr_r ? amts_pkg::AMTS_PROT_INSTR : amts_pkg::AMTS_PROT_DATA;
        end
        else if (ar_hs)
            arvalid <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            awvalid <= 1'b0;
            awaddr <= amts_pkg::AMTS_ADDR_RST;
            awburst <= amts_pkg::AMTS_BURST_INCR;
            awsize <= amts_pkg::AMTS_SIZE_8;
            awlen <= amts_pkg::AMTS_LEN_1;
            awlock <= amts_pkg::AMTS_LOCK_NORMAL;
            awprot <= amts_pkg::AMTS_PROT_DATA;
        end
        else if (state_r == amts_pkg::AMTS_ST_ISSUE && job_write_r)
        begin
            awvalid <= 1'b1;
            awaddr <= sh_addr;
            awburst <= amts_pkg::AMTS_BURST_INCR;
            awsize <= sh_size;
            awlen <= sh_len;
            awlock <= job_lock_r;
            awprot <= amts_pkg::AMTS_PROT_DATA;
        end
        else if (aw_hs)
            awvalid <= 1'b0;
    end

    amts_beat_cnt u_beat_cnt (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(aw_hs),
        .load_len(awlen),
        .step(st_take),
        .last(beat_last)
    );

    amts_byte_store_gen u_byte_store_gen (
        .lane_addr(w_lane_r),
        .beat_size(w_size_r),
        .byte_store(beat_byte_store)
    );

    assign wvalid_nxt = st_take || (wvalid && !wready);

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            w_lane_r <= 3'h0;
            w_size_r <= amts_pkg::AMTS_SIZE_8;
            w_all_r <= 1'b0;
        end
        else if (aw_hs)
        begin
            w_lane_r <= awaddr[2:0];
            w_size_r <= awsize;
            w_all_r <= 1'b0;
        end
        else if (st_take)
        begin
            w_lane_r <= w_lane_r + 3'(4'h1 << w_size_r);
            w_all_r <= beat_last;
        end
    end

    // one burst of beats at a time
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            st_ready <= 1'b0;
        else
            st_ready <= (state_nxt == amts_pkg::AMTS_ST_DATA) && !wvalid_nxt
                && !(w_all_r || (st_take && beat_last)) && !aw_hs;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wvalid <= 1'b0;
            wdata <= amts_pkg::AMTS_DATA_RST;
            wstrb <= amts_pkg::AMTS_BYTE_STORE_RST;
            wlast <= 1'b0;
        end
        else if (st_take)
        begin
            wvalid <= 1'b1;
            wdata <= st_data;
            wstrb <= beat_byte_store;
            wlast <= beat_last;
        end
        else if (w_hs)
            wvalid <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            bready <= amts_pkg::AMTS_ACCEPT_RST;
            rready <= amts_pkg::AMTS_ACCEPT_RST;
        end
        else
        begin
            bready <= 1'b1;
            rready <= 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ld_valid <= 1'b0;
            ld_data <= amts_pkg::AMTS_DATA_RST;
            ld_last <= 1'b0;
            ld_resp <= 2'h0;
            st_done <= 1'b0;
            st_resp <= 2'h0;
        end
        else
        begin
            ld_valid <= rvalid;
            ld_data <= rdata;
            ld_last <= rlast;
            ld_resp <= rresp;
            st_done <= bvalid;
            st_resp <= bresp;
        end
    end

    property p_len_max;
        @(posedge core_clk) disable iff (sys_rst)
        (arvalid |-> arlen <= amts_pkg::AMTS_LEN_MAX)
            and (awvalid |-> awlen <= amts_pkg::AMTS_LEN_MAX);
    endproperty
    a_len_max: assert property (p_len_max) else $error("burst longer than 8");

    property p_bytes_max;
        @(posedge core_clk) disable iff (sys_rst)
        arvalid |-> ((9'(arlen) + 9'h1) << arsize) <= 9'h020;
    endproperty
    a_bytes_max: assert property (p_bytes_max) else $error("burst over 32 bytes");

    property p_no_cross;
        @(posedge core_clk) disable iff (sys_rst)
        ((awvalid && awburst == amts_pkg::AMTS_BURST_INCR)
            |-> (9'(awaddr[4:0]) + ((9'(awlen) + 9'h1) << awsize)) <= 9'h020)
            and ((arvalid && arburst == amts_pkg::AMTS_BURST_INCR)
            |-> (9'(araddr[4:0]) + ((9'(arlen) + 9'h1) << arsize)) <= 9'h020);
    endproperty
    a_no_cross: assert property (p_no_cross) else $error("burst crosses region");

    property p_burst_type;
        @(posedge core_clk) disable iff (sys_rst)
        (awvalid |-> awburst == amts_pkg::AMTS_BURST_INCR)
            and (arvalid |-> arburst != amts_pkg::AMTS_BURST_FIXED);
    endproperty
    a_burst_type: assert property (p_burst_type) else $error("illegal burst type");

    property p_wrap_shape;
        @(posedge core_clk) disable iff (sys_rst)
        (arvalid && arburst == amts_pkg::AMTS_BURST_WRAP)
            |-> arsize == amts_pkg::AMTS_SIZE_64 && arlen == amts_pkg::AMTS_LEN_4
            && araddr[2:0] == 3'h0 && job_fill_ok_r;
    endproperty
    a_wrap_shape: assert property (p_wrap_shape) else $error("bad wrap burst");

    property p_narrow_single;
        @(posedge core_clk) disable iff (sys_rst)
        (arvalid && arsize <= amts_pkg::AMTS_SIZE_16 |-> arlen == amts_pkg::AMTS_LEN_1)
            and (awvalid && awsize <= amts_pkg::AMTS_SIZE_16 |-> awlen == amts_pkg::AMTS_LEN_1)
            and (wvalid && w_size_r <= amts_pkg::AMTS_SIZE_16 |-> $countones(wstrb) <= 2);
    endproperty
    a_narrow_single: assert property (p_narrow_single) else $error("narrow burst");

    property p_fetch;
        @(posedge core_clk) disable iff (sys_rst)
        (arvalid && arprot[2]) |-> arsize == amts_pkg::AMTS_SIZE_64
            && arlock == amts_pkg::AMTS_LOCK_NORMAL && arsize <= amts_pkg::AMTS_SIZE_64;
    endproperty
    a_fetch: assert property (p_fetch) else $error("bad fetch shape");

    property p_fault_quiet;
        @(posedge core_clk) disable iff (sys_rst)
        align_fault |-> state_r == amts_pkg::AMTS_ST_IDLE && !arvalid && !awvalid
            ##1 state_r == amts_pkg::AMTS_ST_IDLE;
    endproperty
    a_fault_quiet: assert property (p_fault_quiet) else $error("fault issued transfer");

    property p_w_order;
        @(posedge core_clk) disable iff (sys_rst)
        wvalid |-> state_r == amts_pkg::AMTS_ST_DATA && !awvalid;
    endproperty
    a_w_order: assert property (p_w_order) else $error("write data interleaved");

    property p_ready_high;
        @(posedge core_clk) disable iff (sys_rst)
        $past(sys_rst) == 1'b0 |-> bready && rready;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("response ready dropped");

    property p_dev_issue;
        @(posedge core_clk) disable iff (sys_rst)
        (take_req && dev_mem && !misalign) |-> ##2 (arvalid || awvalid);
    endproperty
    a_dev_issue: assert property (p_dev_issue) else $error("device access lost");
endmodule : amts_top

//--- pkg/amts_pkg.sv
// constants and types of the transaction shaper
package amts_pkg;
    localparam int AMTS_ADDR_W = 32;
    localparam int AMTS_DATA_W = 64;
    localparam int AMTS_BYTE_STORE_W = 8;

    localparam logic [1:0] AMTS_BURST_FIXED = 2'h0;
    localparam logic [1:0] AMTS_BURST_INCR = 2'h1;
    localparam logic [1:0] AMTS_BURST_WRAP = 2'h2;

    localparam logic [2:0] AMTS_SIZE_8 = 3'h0;
    localparam logic [2:0] AMTS_SIZE_16 = 3'h1;
    localparam logic [2:0] AMTS_SIZE_32 = 3'h2;
    localparam logic [2:0] AMTS_SIZE_64 = 3'h3;

    localparam logic [7:0] AMTS_LEN_1 = 8'h00;
    localparam logic [7:0] AMTS_LEN_4 = 8'h03;
    localparam logic [7:0] AMTS_LEN_MAX = 8'h07;

    localparam logic [3:0] AMTS_WORDS_PER_REGION = 4'h8;
    localparam logic [5:0] AMTS_REGION_BYTES = 6'h20;
    localparam logic [4:0] AMTS_DWORD_WORDS = 5'h02;

    localparam logic [1:0] AMTS_LOCK_NORMAL = 2'h0;
    localparam logic [1:0] AMTS_LOCK_EXCL = 2'h1;
    localparam logic [1:0] AMTS_LOCK_LOCKED = 2'h2;
    localparam logic [2:0] AMTS_PROT_DATA = 3'h0;
    localparam logic [2:0] AMTS_PROT_INSTR = 3'h4;

    localparam logic AMTS_ACCEPT_RST = 1'b1;
    localparam logic [31:0] AMTS_ADDR_RST = 32'h00000000;
    localparam logic [63:0] AMTS_DATA_RST = 64'h0000000000000000;
    localparam logic [7:0] AMTS_BYTE_STORE_RST = 8'h00;

    typedef enum logic [2:0] {
        AMTS_MEM_SO,
        AMTS_MEM_DEV,
        AMTS_MEM_NC,
        AMTS_MEM_WT,
        AMTS_MEM_WB
    } amts_mem_type;

    typedef enum logic [2:0] {
        AMTS_OP_BYTE,
        AMTS_OP_HALF,
        AMTS_OP_WORD,
        AMTS_OP_MULTI,
        AMTS_OP_DWORD,
        AMTS_OP_FETCH,
        AMTS_OP_LINEFILL,
        AMTS_OP_EVICT
    } amts_op_type;

    typedef enum {
        AMTS_ST_IDLE,
        AMTS_ST_ISSUE,
        AMTS_ST_ADDR,
        AMTS_ST_DATA
    } amts_state_type;
endpackage : amts_pkg

//--- tb/amts_slave.sv
// axi slave model facing the shaper
module amts_slave (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic arvalid,
    input wire logic [7:0] arlen,
    output logic arready,
    input wire logic awvalid,
    output logic awready,
    input wire logic wvalid,
    input wire logic wlast,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    output logic [63:0] rdata,
    output logic [1:0] rresp,
    output logic rlast,
    output logic rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] rcnt_r;
    assign bresp = {2{~bvalid}};
    assign rresp = {2{~rvalid}};
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            {arready, awready, wready, bvalid, rvalid, rlast} <= 6'h00;
            rcnt_r <= 9'h000;
            rdata <= 64'h0;
        end
        else
        begin
            arready <= slow ? ~arready : 1'b1;
            awready <= slow ? ~awready : 1'b1;
            wready <= slow ? ~wready : 1'b1;
            bvalid <= wvalid && wready && wlast;
            rvalid <= rcnt_r != 9'h000;
            rlast <= rcnt_r == 9'h001;
            rdata <= (rcnt_r != 9'h000) ? {55'h0, rcnt_r} : ~rdata;
            rcnt_r <= rcnt_r - {8'h00, rcnt_r != 9'h000}
                + ((arvalid && arready) ? {1'b0, arlen} + 9'h001 : 9'h000);
        end
    end
endmodule : amts_slave

//--- tb/axi_master_transaction_shaper_test.sv
// self-checking bench of the transaction shaper
module axi_master_transaction_shaper_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, req_valid, req_ready, req_write, req_shared, req_instr, req_excl;
    logic req_lock, req_sb_hit, st_valid, st_ready, align_fault, sb_absorbed, ld_valid, ld_last;
    logic st_done, arvalid, arready, awvalid, awready, wlast, wvalid, wready, bvalid, bready;
    logic rlast, rvalid, rready, slow;
    amts_pkg::amts_op_type req_op;
    amts_pkg::amts_mem_type req_mem;
    logic [31:0] req_addr, araddr, awaddr, lf;
    logic [4:0] req_nwords;
    logic [63:0] st_data, ld_data, wdata, rdata;
    logic [1:0] ld_resp, st_resp, arburst, arlock, awburst, awlock, bresp, rresp;
    logic [2:0] arsize, arprot, awsize, awprot;
    logic [7:0] arlen, awlen, wstrb;
    logic [63:0] ex[$];
    logic [70:0] pr = '0;
    int errors, num_checks;
    amts_top amts_top_inst (.*);
    amts_slave amts_slave_inst (.*);
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    function logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    function logic [63:0] ev(input logic [3:0] k, input logic [31:0] a, input logic [1:0] b,
        input logic [2:0] s, input logic [7:0] l, input logic [2:0] p, input logic [7:0] st);
        return {4'h0, k, p, a, b, s, l, st};
    endfunction : ev
    task chk(input logic [70:0] s, input logic [70:0] e);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task see(input logic [63:0] v);
        chk({bready, rready}, 64'h3);
        chk(v, ex.size() ? ex.pop_front() : '1);
    endtask : see
    always @(posedge core_clk)
    begin
        if (!sys_rst)
        begin
            chk({ld_data, ld_valid, ld_last, ld_resp, st_done, st_resp}, pr);
            pr = {rdata, rvalid, rlast, rresp, bvalid, bresp};
            if (arvalid && arready)
                see(ev(1, araddr, arburst, arsize, arlen, arprot, 0) | {arlock, 62'h0});
            if (awvalid && awready)
                see(ev(2, awaddr, awburst, awsize, awlen, awprot, 0) | {awlock, 62'h0});
            if (wvalid && wready) see(ev(3, 0, wlast, 0, 0, 0, wstrb));
            if (wvalid && wready) chk(wdata, st_data);
            if (align_fault) see(ev(4, 0, 0, 0, 0, 0, 0));
            if (sb_absorbed) see(ev(5, 0, 0, 0, 0, 0, 0));
        end
    end
    task go(input logic w, input amts_pkg::amts_op_type op, input amts_pkg::amts_mem_type m,
        input logic [31:0] a, input logic sb);
        int i;
        {req_valid, req_write, req_sb_hit} = {1'b1, w, sb};
        req_instr = op == amts_pkg::AMTS_OP_FETCH;
        req_op = op;
        req_mem = m;
        req_addr = a;
        st_data = {lf, ~lf};
        while (req_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
        for (i = 0; i < 60 && req_ready !== 1'b1; i++) @(negedge core_clk);
        if (i == 60) errors++;
    endtask : go
    task automatic one(input int k);
        int o = k / 16;
        int sz = (o > 3) ? o - 4 : ((o == 3) ? 2 : o);
        logic [31:0] a;
        lf = nxt(lf);
        a = {lf[31:5], 1'b0, k[3:0]};
        if ((a & ((1 << sz) - 1)) != 0) ex.push_back(ev(4, 0, 0, 0, 0, 0, 0));
        else if (o > 3)
        begin
            ex.push_back(ev(2, a, 1, sz, 0, 0, 0));
            ex.push_back(ev(3, 0, 1, 0, 0, 0, ((1 << (1 << sz)) - 1) << a[2:0]));
        end
        else ex.push_back(ev(1, a, 1, sz, (o == 3) ? 4 : 0, 0, 0));
        go(o > 3, amts_pkg::amts_op_type'((o > 3) ? o - 4 : o),
            a[1] ? amts_pkg::AMTS_MEM_DEV : amts_pkg::AMTS_MEM_SO, a, lf[0]);
    endtask : one
    task results;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial
    begin
        #400us;
        errors++;
        results();
    end
    initial
    begin
        {sys_rst, req_valid, req_write, req_shared, req_instr, req_excl, req_lock} = 7'h40;
        {req_sb_hit, st_valid, slow, req_nwords, st_data} = {3'b010, 5'h05, 64'h0};
        {req_addr, lf, errors, num_checks} = {32'h0, 32'h91C28D46, 64'h0};
        req_op = amts_pkg::AMTS_OP_BYTE;
        req_mem = amts_pkg::AMTS_MEM_SO;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        for (int ph = 0; ph < 2; ph++)
        begin
            slow = ph[0];
            for (int k = 0; k < 96; k++) one(k);
            $display("phase %0d done", ph);
        end
        req_excl = 1'b1;
        ex.push_back(ev(4, 0, 0, 0, 0, 0, 0));
        go(1'b0, amts_pkg::AMTS_OP_WORD, amts_pkg::AMTS_MEM_NC, 32'h102, 1'b0);
        ex.push_back(ev(1, 32'h104, 1, 2, 0, 0, 0) | {2'h1, 62'h0});
        go(1'b0, amts_pkg::AMTS_OP_WORD, amts_pkg::AMTS_MEM_NC, 32'h104, 1'b0);
        req_excl = 1'b0;
        ex.push_back(ev(1, 32'h318, 1, 2, 1, 0, 0));
        ex.push_back(ev(1, 32'h320, 1, 2, 2, 0, 0));
        go(1'b0, amts_pkg::AMTS_OP_MULTI, amts_pkg::AMTS_MEM_SO, 32'h318, 1'b0);
        ex.push_back(ev(1, 32'h33C, 1, 2, 0, 0, 0));
        ex.push_back(ev(1, 32'h340, 1, 2, 0, 0, 0));
        go(1'b0, amts_pkg::AMTS_OP_DWORD, amts_pkg::AMTS_MEM_DEV, 32'h33C, 1'b0);
        ex.push_back(ev(5, 0, 0, 0, 0, 0, 0));
        go(1'b0, amts_pkg::AMTS_OP_BYTE, amts_pkg::AMTS_MEM_NC, 32'h200, 1'b1);
        req_lock = 1'b1;
        ex.push_back(ev(1, lf & ~32'h7, 1, 3, 0, 4, 0));
        go(1'b0, amts_pkg::AMTS_OP_FETCH, amts_pkg::AMTS_MEM_WB, lf, 1'b0);
        req_lock = 1'b0;
        ex.push_back(ev(1, lf & ~32'h7, 2, 3, 3, 0, 0));
        go(1'b0, amts_pkg::AMTS_OP_LINEFILL, amts_pkg::AMTS_MEM_WB, lf, 1'b0);
        req_shared = 1'b1;
        ex.push_back(ev(1, lf & ~32'h7, 1, 3, 0, 0, 0));
        go(1'b0, amts_pkg::AMTS_OP_LINEFILL, amts_pkg::AMTS_MEM_WB, lf, 1'b0);
        ex.push_back(ev(2, lf & ~32'h1F, 1, 3, 3, 0, 0));
        for (int i = 0; i < 4; i++) ex.push_back(ev(3, 0, i == 3, 0, 0, 0, 8'hFF));
        go(1'b1, amts_pkg::AMTS_OP_EVICT, amts_pkg::AMTS_MEM_WB, lf, 1'b0);
        repeat (20) @(negedge core_clk);
        chk(ex.size(), 64'h0);
        $display("special tests done");
        results();
    end
endmodule : axi_master_transaction_shaper_test
